// >>> logic/dbg_pkg.sv
package dbg_pkg;

	localparam logic [7:0] DBG_ADDR_FIRST_DATA = 8'h06;
	localparam logic [7:0] DBG_ADDR_SECOND_DATA = 8'h07;
	localparam logic [7:0] DBG_ADDR_INT_CTRL = 8'h0b;
	localparam logic [7:0] DBG_ADDR_INT_CTRL_HI = 8'h8b;
	localparam logic [7:0] DBG_ADDR_OPTION = 8'h81;
	localparam logic [7:0] DBG_ADDR_FIRST_DIR = 8'h86;
	localparam logic [7:0] DBG_ADDR_SECOND_DIR = 8'h87;

	localparam logic [7:0] DBG_DIR_RESET = 8'hff;
	localparam logic [7:0] DBG_OPTION_RESET = 8'hff;
	localparam logic [7:0] DBG_LATCH_POR = 8'h00;
	localparam logic [7:0] DBG_INT_CTRL_POR = 8'h00;
	localparam logic [7:0] DBG_INT_CTRL_KEEP = 8'h81;
	localparam logic [7:0] DBG_CHANGE_MASK = 8'hf0;

	localparam int DBG_OPT_PULLUP_DIS_N = 7;
	localparam int DBG_OPT_INT_EDGE = 6;
	localparam int DBG_INTC_EXT_EN = 4;
	localparam int DBG_INTC_EXT_FLAG = 1;
	localparam int DBG_INTC_CHANGE_FLAG = 0;
	localparam int DBG_IRQ_BIT = 0;
	localparam int DBG_PROG_CLK_BIT = 6;
	localparam int DBG_PROG_DATA_BIT = 7;

	typedef enum logic [1:0]
	{
		DBG_OP_WRITE = 2'h0,
		DBG_OP_BIT_SET = 2'h1,
		DBG_OP_BIT_CLEAR = 2'h3
	} dbg_op_t;

	typedef struct packed
	{
		logic rd;
		logic wr;
		dbg_op_t op;
		logic [2:0] bit_idx;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dbg_req_t;

endpackage : dbg_pkg

// >>> logic/dbg_gpio.sv
`timescale 1ns/1ps
module dbg_gpio
	import dbg_pkg::*;
#(
	parameter bit HAS_SECOND_PORT = 1'b1
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic por,
	input wire dbg_req_t req,
	output logic [7:0] rdata_q,
	input wire logic [7:0] first_pin_in,
	output logic [7:0] first_pin_out_q,
	output logic [7:0] first_pin_oe_n_q,
	output logic [7:0] first_pullup_en_q,
	input wire logic [7:0] second_pin_in,
	output logic [7:0] second_pin_out_q,
	output logic [7:0] second_pin_oe_n_q,
	input wire logic prog_mode,
	input wire logic prog_data_out,
	input wire logic prog_data_drive,
	output logic program_clock_pin_q,
	output logic program_data_pin_q,
	output logic irq_level_q,
	output logic change_interrupt_flag_q
);

	// Bit operations act on whatever base value the caller supplies
	function automatic logic [7:0] apply_op(
		input logic [7:0] base,
		input dbg_req_t r
	);
		logic [7:0] one_hot;
		one_hot = 8'h01 << r.bit_idx;
		case (r.op)
			DBG_OP_BIT_SET: apply_op = base | one_hot;
			DBG_OP_BIT_CLEAR: apply_op = base & ~one_hot;
			default: apply_op = r.wdata;
		endcase
	endfunction : apply_op

	function automatic logic hit(
		input dbg_req_t r,
		input logic [7:0] a
	);
		hit = r.wr && (r.addr == a);
	endfunction : hit

	if (HAS_SECOND_PORT !== 1'b0 && HAS_SECOND_PORT !== 1'b1)
	begin : g_bad_param
		$error("HAS_SECOND_PORT must be 0 or 1");
	end

	logic [7:0] first_latch_q, first_latch_d;
	logic [7:0] second_latch_q, second_latch_d;
	logic [7:0] first_dir_q, first_dir_d;
	logic [7:0] second_dir_q, second_dir_d;
	logic [7:0] option_q, option_d;
	logic [7:0] int_ctrl_q, int_ctrl_d;
	logic [7:0] last_read_q, last_read_d;
	logic irq_filt_q, irq_filt_d;
	logic irq_prev_q, irq_prev_d;
	logic irq_hold_q, irq_hold_d;
	logic [7:0] rdata_d;
	logic [7:0] first_out_d, first_oe_n_d, pullup_d;
	logic [7:0] second_out_d, second_oe_n_d;
	logic mismatch;
	logic ext_edge;
	logic touch_first;

	// Register state
	always_comb
	begin
		first_latch_d = first_latch_q;
		second_latch_d = second_latch_q;
		first_dir_d = first_dir_q;
		second_dir_d = second_dir_q;
		option_d = option_q;
		int_ctrl_d = int_ctrl_q;
		last_read_d = last_read_q;
		// Any access to the first port ends the mismatch
		if (touch_first)
		begin
			last_read_d = first_pin_in;
		end
		// Base is the sampled pins, so input latches take pin levels
		if (hit(req, DBG_ADDR_FIRST_DATA))
		begin
			first_latch_d = apply_op(first_pin_in, req);
		end
		else if (hit(req, DBG_ADDR_SECOND_DATA) && HAS_SECOND_PORT)
		begin
			second_latch_d = apply_op(second_pin_in, req);
		end
		else if (hit(req, DBG_ADDR_FIRST_DIR))
		begin
			first_dir_d = apply_op(first_dir_q, req);
		end
		else if (hit(req, DBG_ADDR_SECOND_DIR) && HAS_SECOND_PORT)
		begin
			second_dir_d = apply_op(second_dir_q, req);
		end
		else if (hit(req, DBG_ADDR_OPTION))
		begin
			option_d = apply_op(option_q, req);
		end
		else if (hit(req, DBG_ADDR_INT_CTRL) || hit(req, DBG_ADDR_INT_CTRL_HI))
		begin
			int_ctrl_d = apply_op(int_ctrl_q, req);
		end
		// Hardware set wins over a software clear in the same cycle
		if (mismatch)
		begin
			int_ctrl_d[DBG_INTC_CHANGE_FLAG] = 1'b1;
		end
		if (ext_edge)
		begin
			int_ctrl_d[DBG_INTC_EXT_FLAG] = 1'b1;
		end
		if (rst)
		begin
			first_dir_d = DBG_DIR_RESET;
			second_dir_d = DBG_DIR_RESET;
			option_d = DBG_OPTION_RESET;
			int_ctrl_d = por ? DBG_INT_CTRL_POR : (int_ctrl_q & DBG_INT_CTRL_KEEP);
			// Latches survive warm reset; cold start picks a known value
			if (por)
			begin
				first_latch_d = DBG_LATCH_POR;
				second_latch_d = DBG_LATCH_POR;
				last_read_d = DBG_LATCH_POR;
			end
			else
			begin
				first_latch_d = first_latch_q;
				second_latch_d = second_latch_q;
				last_read_d = last_read_q;
			end
		end
	end

	// Only input pins in the upper nibble are compared
	always_comb
	begin
		touch_first = (req.rd || req.wr) && (req.addr == DBG_ADDR_FIRST_DATA);
		mismatch = |((first_pin_in ^ last_read_q) & first_dir_q & DBG_CHANGE_MASK);
		if (prog_mode || touch_first)
		begin
			mismatch = 1'b0;
		end
	end

	// Two agreeing samples stand in for the input hysteresis
	always_comb
	begin
		irq_hold_d = first_pin_in[DBG_IRQ_BIT];
		irq_filt_d = irq_filt_q;
		if (first_pin_in[DBG_IRQ_BIT] == irq_hold_q)
		begin
			irq_filt_d = irq_hold_q;
		end
		irq_prev_d = irq_filt_q;
		ext_edge = int_ctrl_q[DBG_INTC_EXT_EN] && (irq_filt_q != irq_prev_q) &&
			(irq_filt_q == option_q[DBG_OPT_INT_EDGE]);
		if (rst)
		begin
			irq_hold_d = 1'b0;
			irq_filt_d = 1'b0;
			irq_prev_d = 1'b0;
		end
	end

	// Read mux, unmapped addresses read zero
	always_comb
	begin
		rdata_d = rdata_q;
		if (req.rd)
		begin
			if (req.addr == DBG_ADDR_FIRST_DATA)
			begin
				rdata_d = first_pin_in;
			end
			else if (req.addr == DBG_ADDR_SECOND_DATA)
			begin
				rdata_d = HAS_SECOND_PORT ? second_pin_in : 8'h00;
			end
			else if (req.addr == DBG_ADDR_FIRST_DIR)
			begin
				rdata_d = first_dir_q;
			end
			else if (req.addr == DBG_ADDR_SECOND_DIR)
			begin
				rdata_d = HAS_SECOND_PORT ? second_dir_q : 8'h00;
			end
			else if (req.addr == DBG_ADDR_OPTION)
			begin
				rdata_d = option_q;
			end
			else if (req.addr == DBG_ADDR_INT_CTRL || req.addr == DBG_ADDR_INT_CTRL_HI)
			begin
				rdata_d = int_ctrl_q;
			end
			else
			begin
				rdata_d = 8'h00;
			end
		end
		if (rst)
		begin
			rdata_d = 8'h00;
		end
	end

	// Pin drivers follow the next register values so a cleared
	// direction bit drives the held latch on the same edge
	for (genvar i = 0; i < 8; i++)
	begin : g_pin
		always_comb
		begin
			first_out_d[i] = first_latch_d[i];
			first_oe_n_d[i] = first_dir_d[i];
			second_out_d[i] = HAS_SECOND_PORT ? second_latch_d[i] : 1'b0;
			second_oe_n_d[i] = HAS_SECOND_PORT ? second_dir_d[i] : 1'b1;
			if (prog_mode && i == DBG_PROG_CLK_BIT)
			begin
				first_oe_n_d[i] = 1'b1;
			end
			if (prog_mode && i == DBG_PROG_DATA_BIT)
			begin
				first_out_d[i] = prog_data_out;
				first_oe_n_d[i] = ~prog_data_drive;
			end
			// Pull-up follows the final driver, so a programming drive drops it too
			pullup_d[i] = ~option_d[DBG_OPT_PULLUP_DIS_N] & first_oe_n_d[i];
		end
	end

	always_ff @(posedge clock)
	begin
		first_latch_q <= first_latch_d;
		second_latch_q <= second_latch_d;
		first_dir_q <= first_dir_d;
		second_dir_q <= second_dir_d;
		option_q <= option_d;
		int_ctrl_q <= int_ctrl_d;
		last_read_q <= last_read_d;
		irq_hold_q <= irq_hold_d;
		irq_filt_q <= irq_filt_d;
		irq_prev_q <= irq_prev_d;
		rdata_q <= rdata_d;
		first_pin_out_q <= first_out_d;
		first_pin_oe_n_q <= first_oe_n_d;
		first_pullup_en_q <= pullup_d;
		second_pin_out_q <= second_out_d;
		second_pin_oe_n_q <= second_oe_n_d;
		program_clock_pin_q <= rst ? 1'b0 : (prog_mode & first_pin_in[DBG_PROG_CLK_BIT]);
		program_data_pin_q <= rst ? 1'b0 : (prog_mode & first_pin_in[DBG_PROG_DATA_BIT]);
		irq_level_q <= rst ? 1'b0 : (irq_filt_d & int_ctrl_d[DBG_INTC_EXT_EN]);
		change_interrupt_flag_q <= int_ctrl_d[DBG_INTC_CHANGE_FLAG];
	end

endmodule : dbg_gpio

// >>> verif/dbg_gpio_asserts.sv
`timescale 1ns/1ps
module dbg_gpio_asserts
	import dbg_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire dbg_req_t req,
	input wire logic [7:0] rdata_q,
	input wire logic [7:0] first_pin_in,
	input wire logic [7:0] first_pin_oe_n_q,
	input wire logic [7:0] first_pullup_en_q,
	input wire logic [7:0] second_pin_oe_n_q,
	input wire logic prog_mode,
	input wire logic prog_data_drive,
	input wire logic program_clock_pin_q,
	input wire logic program_data_pin_q,
	input wire logic irq_level_q,
	input wire logic change_interrupt_flag_q
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	wire dwr = req.wr && req.op == DBG_OP_WRITE;
	dir_reset_a: assert property (disable iff (1'b0) $fell(rst) |-> first_pin_oe_n_q == 8'hff
		&& second_pin_oe_n_q == 8'hff && first_pullup_en_q == 8'h00) else $error("dir reset");
	dir_write_a: assert property (dwr && req.addr == DBG_ADDR_FIRST_DIR && !prog_mode
		|=> first_pin_oe_n_q == $past(req.wdata)) else $error("dir write");
	sec_dir_a: assert property (dwr && req.addr == DBG_ADDR_SECOND_DIR
		|=> second_pin_oe_n_q == $past(req.wdata)) else $error("second dir");
	read_pins_a: assert property (req.rd && req.addr == DBG_ADDR_FIRST_DATA
		|=> rdata_q == $past(first_pin_in)) else $error("read pins");
	pullup_out_a: assert property ((first_pullup_en_q & ~first_pin_oe_n_q) == 8'h00)
		else $error("pull-up on output");
	pullup_on_a: assert property (dwr && req.addr == DBG_ADDR_OPTION && !req.wdata[7]
		##1 first_pin_oe_n_q == 8'hff |-> first_pullup_en_q == 8'hff) else $error("pull-up");
	prog_clk_a: assert property (program_clock_pin_q == ($past(prog_mode)
		&& $past(first_pin_in[6]))) else $error("prog clock");
	change_mask_a: assert property ($rose(change_interrupt_flag_q)
		|-> $past(first_pin_oe_n_q[7:4]) != 4'h0 || $past(req.wr)) else $error("change");
	prog_data_a: assert property (program_data_pin_q == ($past(prog_mode)
		&& $past(first_pin_in[7]))) else $error("prog data");
	prog_drive_a: assert property (prog_mode && prog_data_drive
		|=> !first_pin_oe_n_q[7] && first_pin_oe_n_q[6]) else $error("prog drive");
	irq_filter_a: assert property (!first_pin_in[0] ##1 !first_pin_in[0]
		|=> !irq_level_q) else $error("irq filter");
	cover property (req.rd && req.addr == DBG_ADDR_FIRST_DATA);
	cover property ($rose(change_interrupt_flag_q));
	cover property (prog_mode && program_clock_pin_q);
endmodule : dbg_gpio_asserts

// >>> verif/dbg_pins.sv
`timescale 1ns/1ps
module dbg_pins
(
	input wire logic clock,
	input wire logic [7:0] out,
	input wire logic [7:0] oe_n,
	input wire logic [7:0] pull,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext,
	output logic [7:0] pin
);
	logic [7:0] wob_q = 8'h5a;
	always @(posedge clock) wob_q <= ~wob_q;
	// Floating pins wobble so a stale level never reads as valid
	always_comb
		for (int i = 0; i < 8; i++)
			pin[i] = !oe_n[i] ? out[i] : ext_en[i] ? ext[i] : pull[i] ? 1'b1 : wob_q[i];
endmodule : dbg_pins

// >>> verif/dual_bidir_gpio_ports_bench.sv
`timescale 1ns/1ps
module dual_bidir_gpio_ports_bench
	import dbg_pkg::*;
();
	logic clock = 0, rst = 1, por = 1, prog_mode = 0, rd_pend = 0;
	logic pd_out = 0, pd_drv = 0;
	dbg_req_t req = '0;
	logic [7:0] rdata_q, fin, fout, foe, fpu, sin, sout, soe, w, v;
	logic [7:0] ext_en = 8'hff, ext = 8'h00, sext = 8'h00;
	logic [7:0] exp_q[$];
	int err_total = 0, n_tests = 0, seed = 32'h11b7;
	dbg_gpio i_dbg_gpio (.clock(clock), .rst(rst), .por(por), .req(req), .rdata_q(rdata_q),
		.first_pin_in(fin), .first_pin_out_q(fout), .first_pin_oe_n_q(foe),
		.first_pullup_en_q(fpu), .second_pin_in(sin), .second_pin_out_q(sout),
		.second_pin_oe_n_q(soe), .prog_mode(prog_mode), .prog_data_out(pd_out),
		.prog_data_drive(pd_drv), .program_clock_pin_q(), .program_data_pin_q(),
		.irq_level_q(), .change_interrupt_flag_q());
	dbg_pins i_dbg_pins (.clock(clock), .out(fout), .oe_n(foe), .pull(fpu), .ext_en(ext_en),
		.ext(ext), .pin(fin));
	dbg_pins i_dbg_pins_2 (.clock(clock), .out(sout), .oe_n(soe), .pull(8'h00),
		.ext_en(8'hff), .ext(sext), .pin(sin));
	initial
		forever #50 clock = ~clock;
	task automatic give_verdict();
		if (err_total == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	// One idle cycle between requests keeps each strobe a clean pulse
	task automatic ac(logic w_, logic r_, dbg_op_t o, logic [2:0] b, logic [7:0] a, logic [7:0] d);
		@(posedge clock);
		req <= '{rd: r_, wr: w_, op: o, bit_idx: b, addr: a, wdata: d};
		@(posedge clock);
		req <= '0;
	endtask : ac
	task automatic rd(logic [7:0] a, logic [7:0] e);
		exp_q.push_back(e);
		ac(1'b0, 1'b1, DBG_OP_WRITE, 3'h0, a, e);
	endtask : rd
	task automatic wr(logic [7:0] a, logic [7:0] d);
		ac(1'b1, 1'b0, DBG_OP_WRITE, 3'h0, a, d);
	endtask : wr
	always @(posedge clock)
	begin
		if (rd_pend)
		begin
			n_tests++;
			if (rdata_q !== exp_q[0])
			begin
				err_total++;
				$display("BAD rdata expected %h seen %h", exp_q[0], rdata_q);
			end
			void'(exp_q.pop_front());
		end
		rd_pend <= req.rd;
	end
	initial
	begin
		repeat (2000) @(posedge clock);
		err_total++;
		give_verdict();
	end
	initial
	begin
		repeat (16) @(posedge clock);
		rst <= 0;
		rd(DBG_ADDR_FIRST_DIR, DBG_DIR_RESET);
		rd(DBG_ADDR_SECOND_DIR, DBG_DIR_RESET);
		rd(DBG_ADDR_OPTION, DBG_OPTION_RESET);
		rd(DBG_ADDR_INT_CTRL, DBG_INT_CTRL_POR);
		rd(8'h40, 8'h00);
		ext <= 8'($random(seed));
		sext <= 8'($random(seed));
		w = 8'($random(seed));
		wr(DBG_ADDR_SECOND_DIR, w);
		rd(DBG_ADDR_SECOND_DIR, w);
		wr(DBG_ADDR_SECOND_DIR, DBG_DIR_RESET);
		rd(DBG_ADDR_SECOND_DATA, sext);
		wr(DBG_ADDR_SECOND_DATA, w);
		wr(DBG_ADDR_SECOND_DIR, 8'h00);
		rd(DBG_ADDR_SECOND_DATA, w);
		rd(DBG_ADDR_FIRST_DATA, ext);
		wr(DBG_ADDR_FIRST_DIR, 8'hf0);
		wr(DBG_ADDR_FIRST_DATA, w);
		rd(DBG_ADDR_FIRST_DATA, {ext[7:4], w[3:0]});
		ac(1'b1, 1'b0, DBG_OP_BIT_SET, 3'h1, DBG_ADDR_FIRST_DATA, 8'h00);
		ac(1'b1, 1'b0, DBG_OP_BIT_CLEAR, 3'h0, DBG_ADDR_FIRST_DATA, 8'h00);
		// Input pins of the upper nibble overwrite their latches on each bit op
		v = {ext[7:4], w[3:2], 1'b1, 1'b0};
		ext <= ~ext;
		wr(DBG_ADDR_FIRST_DIR, 8'h00);
		rd(DBG_ADDR_FIRST_DATA, v);
		por <= 0;
		rst <= 1;
		@(posedge clock);
		rst <= 0;
		rd(DBG_ADDR_FIRST_DIR, DBG_DIR_RESET);
		wr(DBG_ADDR_FIRST_DIR, 8'h00);
		rd(DBG_ADDR_FIRST_DATA, v);
		wr(DBG_ADDR_FIRST_DIR, DBG_DIR_RESET);
		prog_mode <= 1;
		pd_drv <= 1;
		repeat (4)
		begin
			@(posedge clock);
			ext <= 8'($random(seed));
			pd_out <= 1'($random(seed));
		end
		prog_mode <= 0;
		pd_drv <= 0;
		ext_en <= 8'h00;
		wr(DBG_ADDR_OPTION, 8'h7f);
		rd(DBG_ADDR_OPTION, 8'h7f);
		rd(DBG_ADDR_FIRST_DATA, 8'hff);
		wr(DBG_ADDR_FIRST_DIR, 8'h55);
		ext_en <= 8'hff;
		ext <= 8'h00;
		wr(DBG_ADDR_FIRST_DIR, DBG_DIR_RESET);
		rd(DBG_ADDR_FIRST_DATA, 8'h00);
		wr(DBG_ADDR_INT_CTRL, 8'h00);
		ext <= 8'h0f;
		repeat (3) @(posedge clock);
		rd(DBG_ADDR_INT_CTRL, 8'h00);
		ext <= 8'h1f;
		repeat (3) @(posedge clock);
		rd(DBG_ADDR_INT_CTRL, 8'h01);
		rd(DBG_ADDR_FIRST_DATA, 8'h1f);
		wr(DBG_ADDR_INT_CTRL, 8'h00);
		rd(DBG_ADDR_INT_CTRL, 8'h00);
		wr(DBG_ADDR_INT_CTRL, 8'h10);
		ext <= 8'h1e;
		repeat (3) @(posedge clock);
		rd(DBG_ADDR_INT_CTRL, 8'h10);
		ext <= 8'h1f;
		repeat (3) @(posedge clock);
		rd(DBG_ADDR_INT_CTRL, 8'h12);
		// Let the monitor compare the last read before the run ends
		repeat (2) @(posedge clock);
		give_verdict();
	end
endmodule : dual_bidir_gpio_ports_bench
bind dbg_gpio dbg_gpio_asserts i_dbg_gpio_asserts (.clock, .rst, .req, .rdata_q, .first_pin_in,
	.first_pin_oe_n_q, .first_pullup_en_q, .second_pin_oe_n_q, .prog_mode, .prog_data_drive,
	.program_clock_pin_q, .program_data_pin_q, .irq_level_q, .change_interrupt_flag_q);
